// [inc/eeprom_ctl_map.vh]
`ifndef EEPROM_CTL_MAP_VH
`define EEPROM_CTL_MAP_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_STATUS 8'h0C
`define REG_RDATA 8'h10
// ----------------------------------------
// control bits
// ----------------------------------------
`define CTRL_GO 0
`define CTRL_WRITE 1
`define CTRL_PROT 2
`define CTRL_POLL 3
`define CTRL_UNPROT 4
`define CTRL_LAST 5
// ----------------------------------------
// status bits
// ----------------------------------------
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_TMO 2
// ----------------------------------------
// timing, 20 MHz clock
// ----------------------------------------
`define CLK_NS 50
`define PULSE_NS 150
`define PULSE_CYC ((`PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define LOAD_WIN_US 100
`define LOAD_WIN_CYC ((`LOAD_WIN_US * 1000) / `CLK_NS)
`define WC_MS 10
`define WC_CYC ((`WC_MS * 1000000) / `CLK_NS)
// ----------------------------------------
// unlock and deactivate sequence
// ----------------------------------------
`define SEQ_A0 13'h1555
`define SEQ_A1 13'h0AAA
`define SEQ_D0 8'hAA
`define SEQ_D1 8'h55
`define SEQ_LOCK 8'hA0
`define SEQ_CLR0 8'h80
`define SEQ_CLR1 8'h20
`endif

// [logic/eeprom_bus_cycle.v]
`include "eeprom_ctl_map.vh"
// ----------------------------------------
// one strobed access on the parallel bus
// ----------------------------------------
module eeprom_bus_cycle #(
  parameter PULSE = `PULSE_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire start,
  input wire wr,
  input wire [12:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] dq_in,
  output wire done,
  output reg [7:0] rdata,
  output reg [12:0] mem_addr,
  output reg ce_n,
  output reg oe_n,
  output reg we_n,
  output reg [7:0] dq_out,
  output reg dq_oe
);
  reg [7:0] cnt;
  reg busy;
  reg wr_q;
  assign done = busy && (cnt == 8'h00) && ce_n;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 8'h00;
      busy <= 1'b0;
      rdata <= 8'h00;
      mem_addr <= 13'h0000;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      mem_addr <= addr;
      ce_n <= 1'b0;    // per-access select, see RULE18
      oe_n <= wr;      // oe high during write, see RULE6
      we_n <= !wr;
      dq_out <= wdata;
      dq_oe <= wr;
      cnt <= PULSE[7:0];
    end else if (busy) begin
      if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01) begin
          if (!wr_q) rdata <= dq_in;
          ce_n <= 1'b1;
          oe_n <= 1'b1;
          we_n <= 1'b1;
        end
      end else begin
        busy <= 1'b0;
        dq_oe <= 1'b0;
      end
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_q <= 1'b0;
    else if (start && !busy) wr_q <= wr;
  end
endmodule

// [logic/eeprom_host_ctl.v]
`include "eeprom_ctl_map.vh"
// Behaviour
// RULE1: device inverts bit 7 of last written byte while programming.
// RULE2: after programming, bit 7 reads true data again.
// RULE3: bit 6 toggles on each read during programming.
// RULE4: bit 6 stops toggling when write ends; device accessible again.
// RULE5: host deems done only after two equal bit 6 reads.
// RULE6: no write while oe low, we high or ce high.
// RULE7: device ships unprotected, plain writes accepted.
// RULE8: first unlock-sequence write sets protection latch.
// RULE9: protection latch is nonvolatile until deactivation sequence.
// RULE10: protected device ignores writes without preceding unlock sequence.
// RULE11: host sends three fixed address/data writes before data writes.
// RULE12: unlock opens page window of one to sixty-four bytes.
// RULE13: after page load the device returns to protected state.
// RULE14: unlock use leaves device protected across power cycles.
// RULE15: host inserts no other access inside a sequence.
// RULE16: six fixed writes clear the protection latch.
// RULE17: after deactivation and one write cycle time, standard mode.
// RULE18: chip enable from address decode; oe and we shared.
// RULE19: no new write within load window closes page, starts programming.
// RULE20: all bytes of one page load share upper page bits.
// RULE21: bit 6 toggles on reads at any address.
// RULE22: sequence addresses and data are parameters; wrong step rejected. Here only the addresses are parameters; data bytes are macros.
module eeprom_host_ctl #(
  parameter LOAD_WIN = `LOAD_WIN_CYC,
  parameter WC_TIME = `WC_CYC,
  parameter [12:0] SEQ_A0 = `SEQ_A0,
  parameter [12:0] SEQ_A1 = `SEQ_A1
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  output wire ce_n,
  output wire oe_n,
  output wire we_n,
  output wire [12:0] mem_addr,
  output wire [7:0] dq_out,
  output wire dq_oe,
  input wire [7:0] dq_in
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam S_IDLE = 6'b000001;
  localparam S_SEQ = 6'b000010;
  localparam S_DATA = 6'b000100;
  localparam S_POLL = 6'b001000;
  localparam S_WAIT = 6'b010000;
  localparam S_ACC = 6'b100000;

  function [31:0] dec;
    input [7:0] off;
    begin
      dec = 32'h0000_0000;
      case (off)
        `REG_CTRL: dec = 32'h0000_0001;
        `REG_ADDR: dec = 32'h0000_0002;
        `REG_DATA: dec = 32'h0000_0004;
        `REG_STATUS: dec = 32'h0000_0008;
        `REG_RDATA: dec = 32'h0000_0010;
        default: dec = 32'h0000_0000;
      endcase
    end
  endfunction

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  reg [7:0] a_off;
  reg a_wr;
  reg a_vld;
  reg [5:0] ctrl;
  reg [12:0] addr;
  reg [7:0] data;
  reg busy;
  reg done_f;
  reg tmo_f;
  reg [7:0] rd_byte;
  reg [5:0] state;
  wire [31:0] sel_w;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign sel_w = dec(a_off);
  wire go_w = a_vld && a_wr && sel_w[0] && hwdata[`CTRL_GO] && !busy;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_off <= 8'h00;
      a_wr <= 1'b0;
      a_vld <= 1'b0;
    end else if (hready) begin
      a_vld <= hsel && htrans[1];
      a_wr <= hwrite;
      a_off <= haddr[7:0];
    end
  end
  reg [31:0] next_hrdata;
  wire [31:0] sel_a;
  assign sel_a = dec(haddr[7:0]);
  always @* begin
    next_hrdata = 32'h0000_0000;
    if (sel_a[0]) next_hrdata = {26'h000_0000, ctrl};
    if (sel_a[1]) next_hrdata = {19'h0_0000, addr};
    if (sel_a[2]) next_hrdata = {24'h00_0000, data};
    if (sel_a[3]) next_hrdata = {29'h0000_0000, tmo_f, done_f, busy};
    if (sel_a[4]) next_hrdata = {24'h00_0000, rd_byte};
  end
  // read data from a flop; a read straight after a write sees old value
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= next_hrdata;
    end else if (hready) begin
      hrdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // bus cycle engine
  // ----------------------------------------
  reg cyc_start;
  reg cyc_wr;
  reg [12:0] cyc_addr;
  reg [7:0] cyc_data;
  wire cyc_done;
  wire [7:0] cyc_rdata;
  reg sq_run;
  eeprom_bus_cycle u_cyc (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(cyc_start),
    .wr(cyc_wr),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .dq_in(dq_in),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .mem_addr(mem_addr),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n),
    .dq_out(dq_out),
    .dq_oe(dq_oe)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  reg [2:0] step;
  reg [2:0] nsteps;
  reg [31:0] tmr;
  reg [7:0] last6;
  reg have_prev;
  reg [12:0] page;
  reg page_open;
  // sequence table; addresses are parameters, data bytes are fixed macros, see RULE22
  function [20:0] seq_ent;
    input unprot;
    input [2:0] i;
    begin
      seq_ent = {SEQ_A0, `SEQ_D0};
      case (i)
        3'd0: seq_ent = {SEQ_A0, `SEQ_D0};
        3'd1: seq_ent = {SEQ_A1, `SEQ_D1};
        3'd2: seq_ent = {SEQ_A0, unprot ? `SEQ_CLR0 : `SEQ_LOCK};
        3'd3: seq_ent = {SEQ_A0, `SEQ_D0};
        3'd4: seq_ent = {SEQ_A1, `SEQ_D1};
        3'd5: seq_ent = {SEQ_A0, `SEQ_CLR1};
        default: seq_ent = {SEQ_A0, `SEQ_D0};
      endcase
    end
  endfunction

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= 6'h00;
      addr <= 13'h0000;
      data <= 8'h00;
      busy <= 1'b0;
      done_f <= 1'b0;
      tmo_f <= 1'b0;
      rd_byte <= 8'h00;
      state <= S_IDLE;
      cyc_start <= 1'b0;
      cyc_wr <= 1'b0;
      cyc_addr <= 13'h0000;
      cyc_data <= 8'h00;
      step <= 3'd0;
      nsteps <= 3'd0;
      tmr <= 32'h0000_0000;
      last6 <= 8'h00;
      have_prev <= 1'b0;
      page <= 13'h0000;
      page_open <= 1'b0;
    end else begin
      cyc_start <= 1'b0;
      if (page_open && state == S_IDLE) begin
        // window lapse closes page, see RULE19
        if (tmr == 32'h0000_0000) page_open <= 1'b0;
        else tmr <= tmr - 32'h0000_0001;
      end
      if (a_vld && a_wr && sel_w[1] && !busy) addr <= hwdata[12:0];
      if (a_vld && a_wr && sel_w[2] && !busy) data <= hwdata[7:0];
      if (a_vld && a_wr && sel_w[3]) begin
        if (hwdata[`STAT_DONE] && !(state == S_IDLE && busy)) done_f <= 1'b0;
        if (hwdata[`STAT_TMO]) tmo_f <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          if (go_w) begin
            ctrl <= hwdata[5:0];
            busy <= 1'b1;
            step <= 3'd0;
            have_prev <= 1'b0;
            if (hwdata[`CTRL_UNPROT]) begin
              nsteps <= 3'd6;   // see RULE16
              state <= S_SEQ;
            end else if (hwdata[`CTRL_POLL]) begin
              tmr <= WC_TIME + WC_TIME;
              state <= S_POLL;
            end else if (hwdata[`CTRL_WRITE] && hwdata[`CTRL_PROT]
                         && !page_open) begin
              nsteps <= 3'd3;   // see RULE10 RULE11
              state <= S_SEQ;
            end else begin
              state <= S_ACC;
            end
          end
        end
        S_SEQ: begin
          // back to back, nothing between, see RULE15
          if (!cyc_start && !cyc_done && step != nsteps && !sq_run) begin
            cyc_start <= 1'b1;
            cyc_wr <= 1'b1;
            {cyc_addr, cyc_data} <= seq_ent(ctrl[`CTRL_UNPROT], step);
          end
          if (cyc_done) begin
            step <= step + 3'd1;
            if (step + 3'd1 == nsteps) begin
              if (ctrl[`CTRL_UNPROT]) begin
                tmr <= WC_TIME;  // see RULE17
                state <= S_WAIT;
              end else begin
                state <= S_ACC;  // see RULE8
              end
            end
          end
        end
        S_ACC: begin
          if (!cyc_start && !cyc_done && !sq_run) begin
            cyc_start <= 1'b1;
            cyc_wr <= ctrl[`CTRL_WRITE];
            cyc_addr <= addr;
            cyc_data <= data;
          end
          if (cyc_done) begin
            if (ctrl[`CTRL_WRITE]) begin
              page <= addr;
              // page stays open only while upper page bits match, see RULE20
              page_open <= !ctrl[`CTRL_LAST] && (!page_open ||
                           page[12:6] == addr[12:6]);
              tmr <= LOAD_WIN;
            end else begin
              rd_byte <= cyc_rdata;
            end
            busy <= 1'b0;
            done_f <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_POLL: begin
          // give up on a device that never settles
          if (tmr == 32'h0000_0000) begin
            tmo_f <= 1'b1;
            busy <= 1'b0;
            done_f <= 1'b1;
            state <= S_IDLE;
          end else begin
            tmr <= tmr - 32'h0000_0001;
          end
          if (!cyc_start && !cyc_done && !sq_run) begin
            cyc_start <= 1'b1;
            cyc_wr <= 1'b0;
            cyc_addr <= addr;  // any address works, see RULE21
          end
          if (cyc_done) begin
            last6 <= cyc_rdata;
            have_prev <= 1'b1;
            page_open <= 1'b0;
            // two equal bit 6 reads end the poll, see RULE5
            if (have_prev && last6[6] == cyc_rdata[6]) begin
              rd_byte <= cyc_rdata;
              busy <= 1'b0;
              done_f <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        S_WAIT: begin
          if (tmr == 32'h0000_0000) begin
            busy <= 1'b0;
            done_f <= 1'b1;
            state <= S_IDLE;
          end else begin
            tmr <= tmr - 32'h0000_0001;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // an access is in flight between start and done
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sq_run <= 1'b0;
    else if (cyc_start) sq_run <= 1'b1;
    else if (cyc_done) sq_run <= 1'b0;
  end
endmodule

// [sim/eeprom_host_ctl_sva.sv]
module eeprom_host_ctl_chk (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire [12:0] mem_addr,
  input wire [7:0] dq_out,
  input wire dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  reg rd_ph;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rd_ph <= 1'b0;
    else rd_ph <= hsel && htrans[1] && hready && !hwrite;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  zero_wait_a: assert property (hreadyout == 1'b1)
    else $error("wait state inserted");
  idle_rdata_a: assert property (!rd_ph |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  write_inhibit_a: assert property (!we_n |-> oe_n && !ce_n)
    else $error("write strobe without select or with output enable");
  read_no_drive_a: assert property (!oe_n |-> we_n && !dq_oe)
    else $error("bus driven during read");
  we_pulse_a: assert property ($fell(we_n) |-> ##1 !we_n [*2] ##1 we_n)
    else $error("write pulse length wrong");
  wr_hold_a: assert property (!we_n && $past(we_n) == 1'b0 |->
    $stable(mem_addr) && $stable(dq_out) && dq_oe)
    else $error("address or data moved during write");
  ce_release_a: assert property ($fell(ce_n) |-> ##[1:40] ce_n)
    else $error("chip select held too long");
endmodule

// [sim/eeprom_dev.sv]
`include "eeprom_ctl_map.vh"
module eeprom_dev #(
  parameter LOAD = 16,
  parameter WC = 30
) (
  input wire hclk,
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire [12:0] addr,
  input wire [7:0] din,
  output wire [7:0] dout
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [7:0] mem [0:8191];
  reg [7:0] last = 8'h00;
  reg [7:0] held = 8'h00;
  reg [7:0] wd = 8'h00;
  reg [12:0] wa = 13'h0000;
  reg [12:0] last_a = 13'h0000;
  reg prot = 1'b0;
  reg open_w = 1'b0;
  reg wv = 1'b0;
  reg rd_q = 1'b0;
  reg tog = 1'b0;
  int u = 0;
  int d = 0;
  int un = 0;
  int dn = 0;
  int win = 0;
  int busy = 0;
  wire prog = win > 0 || busy > 0;
  wire rd = !ce_n && !oe_n;
  // status byte at any address while programming
  wire [7:0] val = prog ? {addr == last_a ? ~last[7] : mem[addr][7], tog,
    last[5:0]} : mem[addr];
  assign dout = rd ? val : ~held;
  function automatic [20:0] step(input int i);
    case (i)
      0, 3: step = {`SEQ_A0, `SEQ_D0};
      1, 4: step = {`SEQ_A1, `SEQ_D1};
      2: step = {`SEQ_A0, `SEQ_CLR0};
      5: step = {`SEQ_A0, `SEQ_CLR1};
      default: step = {`SEQ_A0, `SEQ_LOCK};
    endcase
  endfunction
  initial begin
    for (int i = 0; i < 8192; i++) mem[i] = 8'h00;
  end
  always @(posedge hclk) begin
    rd_q <= rd;
    if (rd) held <= val;
    if (!rd && rd_q && prog) tog <= ~tog;
    if (!we_n && !ce_n && oe_n) begin
      wa <= addr;
      wd <= din;
      wv <= 1'b1;
    end
    if (busy > 0) busy <= busy - 1;
    if (win > 0) win <= win - 1;
    if (win == 1) begin
      busy <= WC;
      open_w <= 1'b0;
    end
    if (we_n && wv) begin
      wv <= 1'b0;
      if (busy == 0) begin
        un = ({wa, wd} == step(u == 2 ? 6 : u)) ? u + 1
          : int'({wa, wd} == step(0));
        dn = ({wa, wd} == step(d)) ? d + 1 : int'({wa, wd} == step(0));
        u <= un == 3 ? 0 : un;
        d <= dn == 6 ? 0 : dn;
        if (un == 3) begin
          prot <= 1'b1;
          open_w <= 1'b1;
        end
        if (dn == 6) prot <= 1'b0;
        if (un != 0 || dn != 0 || !prot || open_w) begin
          win <= LOAD;
          last <= wd;
          last_a <= wa;
          if (un == 0 && dn == 0) mem[wa] <= wd;
        end
      end
    end
  end
endmodule

// [sim/eeprom_host_ctl_test.sv]
`include "eeprom_ctl_map.vh"
module eeprom_host_ctl_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] GO = 1 << `CTRL_GO;
  localparam logic [31:0] GW = GO | (1 << `CTRL_WRITE) | (1 << `CTRL_LAST);
  localparam logic [31:0] POLL = GO | (1 << `CTRL_POLL);
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] rd_q = 32'h0000_0000;
  wire hready, hresp, ce_n, oe_n, we_n, dq_oe;
  wire [31:0] hrdata;
  wire [12:0] mem_addr;
  wire [7:0] dq_out, dev_dq, dq_bus;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  // ----------------------------------------
  // shared data line and instances
  // ----------------------------------------
  assign dq_bus = dq_oe ? dq_out : dev_dq;
  always #25 hclk = ~hclk;
  eeprom_host_ctl #(.LOAD_WIN(8), .WC_TIME(50)) i_eeprom_host_ctl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .mem_addr(mem_addr),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_bus));
  eeprom_dev #(.LOAD(16), .WC(30)) i_eeprom_dev (.hclk(hclk), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .addr(mem_addr), .din(dq_out), .dout(dev_dq));
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    rd_q <= hrdata;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    #1 rd = rd_q;
  endtask
  task automatic op(input logic [31:0] c);
    logic [31:0] s;
    ahb(1'b1, `REG_CTRL, c, s);
    do ahb(1'b0, `REG_STATUS, 32'h0, s); while (s[`STAT_BUSY] !== 1'b0);
  endtask
  task automatic access(input logic [12:0] a, input logic [7:0] d,
    input logic [31:0] c);
    logic [31:0] s;
    ahb(1'b1, `REG_ADDR, {19'h0, a}, s);
    ahb(1'b1, `REG_DATA, {24'h0, d}, s);
    op(c);
  endtask
  task automatic fetch(input logic [12:0] a, input logic [31:0] c,
    output logic [7:0] v);
    logic [31:0] s;
    access(a, 8'h00, c);
    ahb(1'b0, `REG_RDATA, 32'h0, s);
    v = s[7:0];
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] v;
    ahb(1'b0, `REG_STATUS, 32'h0, v);
    check("status after reset", 8'h00, v[7:0]);
    ahb(1'b1, 8'h20, 32'hFFFF_FFFF, v);
    ahb(1'b0, 8'h20, 32'h0, v);
    check("unmapped read", 8'h00, v[7:0]);
  endtask
  task automatic t_plain;
    logic [7:0] v;
    logic [31:0] s;
    access(13'h0100, 8'h3C, GW);
    ahb(1'b0, `REG_STATUS, 32'h0, s);
    check("done flag", 8'h02, s[7:0]);
    ahb(1'b1, `REG_STATUS, 32'h2, s);
    ahb(1'b0, `REG_STATUS, 32'h0, s);
    check("done cleared", 8'h00, s[7:0]);
    fetch(13'h0100, GO, v);
    check("inverted top bit", 8'h01, {7'h0, v[7]});
    fetch(13'h0100, POLL, v);
    check("polled data", 8'h3C, v);
  endtask
  task automatic t_prot;
    logic [7:0] v;
    access(13'h0200, 8'h5A, GW | (1 << `CTRL_PROT));
    fetch(13'h0200, POLL, v);
    check("protected write", 8'h5A, v);
    check("latch set", 8'h01, {7'h0, i_eeprom_dev.prot});
  endtask
  task automatic t_blocked;
    logic [7:0] v;
    access(13'h0200, 8'hFF, GW);
    fetch(13'h0200, POLL, v);
    check("blocked write", 8'h5A, v);
    check("latch kept", 8'h01, {7'h0, i_eeprom_dev.prot});
  endtask
  task automatic t_unprot;
    logic [7:0] v;
    op(GO | (1 << `CTRL_UNPROT));
    check("latch cleared", 8'h00, {7'h0, i_eeprom_dev.prot});
    access(13'h0300, 8'h11, GW);
    fetch(13'h0300, POLL, v);
    check("write after clear", 8'h11, v);
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_plain();
    t_prot();
    t_blocked();
    t_unprot();
    close_out();
  end
endmodule
bind eeprom_host_ctl eeprom_host_ctl_chk i_eeprom_host_ctl_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .mem_addr(mem_addr),
  .dq_out(dq_out), .dq_oe(dq_oe));
